// File: pkg/pmic_pkg.sv
/*
 * pmic_pkg: register map, field positions, reset values, timing and
 * multiplier tables for the PLL multiplier and top-level interrupt block.
 * Assumes a 100 MHz core clock and an 8-bit internal register port.
 */
package pmic_pkg;

  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0] PLL_MULTIPLIER_CONFIG_ADDR = 8'h01;
  localparam logic [7:0] WAKEUP_IRQ_ENABLE_ADDR     = 8'h02;
  localparam logic [7:0] SYSTEM_IRQ_ENABLE_ADDR     = 8'h03;
  localparam logic [7:0] CHANNEL_IRQ_ENABLE_ADDR    = 8'h04;
  localparam logic [7:0] WAKEUP_INIT_IRQ_FLAGS_ADDR = 8'h10;
  localparam logic [7:0] SYSTEM_IRQ_FLAGS_ADDR      = 8'h11;
  localparam logic [7:0] CHANNEL_IRQ_SUMMARY_ADDR   = 8'h12;
  localparam logic [7:0] DEVICE_STATUS_ADDR         = 8'h13;
  // per-channel error flag registers, channels 1 to 4
  localparam logic [7:0] CH1_ERROR_FLAGS_ADDR       = 8'h50;
  localparam logic [7:0] CH2_ERROR_FLAGS_ADDR       = 8'h80;
  localparam logic [7:0] CH3_ERROR_FLAGS_ADDR       = 8'hB0;
  localparam logic [7:0] CH4_ERROR_FLAGS_ADDR       = 8'hE0;
  // status flag register sits one address above the error one
  localparam logic [7:0] CH_STATUS_FLAGS_STEP       = 8'h01;

  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int MULT_SEL_MSB        = 3;
  localparam int INIT_DONE_BIT       = 7;
  localparam int OVERTEMP_BIT        = 5;
  localparam int PLL_UNLOCK_BIT      = 4;
  localparam int PLL_LOCK_BIT        = 3;
  localparam int REF_FAIL_BIT        = 2;
  localparam int SERIAL_ERR_BIT      = 1;
  localparam int SLEEP_FAIL_BIT      = 0;
  localparam int CH_ERROR_LSB        = 4;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [3:0] MULT_SEL_RESET        = 4'hA;
  localparam logic [3:0] WAKEUP_EN_RESET       = 4'hF;
  localparam logic [7:0] SYSTEM_EN_RESET       = 8'h00;
  localparam logic [7:0] CHANNEL_EN_RESET      = 8'h00;
  localparam logic [7:0] WAKEUP_FLAGS_RESET    = 8'h80;
  localparam logic [7:0] SYSTEM_FLAGS_RESET    = 8'h00;
  localparam logic [5:1] SYSTEM_EN_MASK        = 5'h1F;

  // ***************************************************************
  // timing: reference frequency is measured over a fixed gate
  // ***************************************************************
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int FREQ_GATE_TIME_NS  = 100000;
  localparam int FREQ_GATE_CYCLES   = FREQ_GATE_TIME_NS / CORE_CLK_PERIOD_NS;
  localparam int LOCK_GOOD_GATES    = 2;

  // ***************************************************************
  // multiplier codes: factor x10 and reference edges per gate
  // ***************************************************************
  localparam logic [3:0] MULT_CODE_LAST = 4'hA;
  localparam logic [9:0] MULT_X10 [0:10] = '{
    10'd780, 10'd650, 10'd390, 10'd280, 10'd200, 10'd150,
    10'd110, 10'd85, 10'd64, 10'd48, 10'd39};
  localparam logic [10:0] REF_EDGES_LO [0:10] = '{
    11'd40, 11'd50, 11'd70, 11'd100, 11'd140, 11'd190,
    11'd260, 11'd350, 11'd450, 11'd600, 11'd800};
  localparam logic [10:0] REF_EDGES_HI [0:10] = '{
    11'd50, 11'd70, 11'd100, 11'd140, 11'd190, 11'd260,
    11'd350, 11'd450, 11'd600, 11'd800, 11'd1000};

  typedef enum logic [2:0] {
    PMIC_UNLOCKED = 3'b001,
    PMIC_SETTLING = 3'b010,
    PMIC_LOCKED   = 3'b100
  } pmic_lock_e;

endpackage : pmic_pkg

// File: hw/pmic_ref_meter.sv
/*
 * pmic_ref_meter: counts rising edges of the external reference clock
 * over a gate of core cycles and checks them against the range of the
 * selected multiplier code.
 * Assumes ref_clk is asynchronous to core_clk and slower than half of it.
 */
`timescale 1ns/10ps
module pmic_ref_meter
  import pmic_pkg::*;
#(
  parameter int GATE_CYCLES = FREQ_GATE_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // reference clock pin
  input  wire logic       ref_clk,
  // selected multiplier code
  input  wire logic [3:0] multiplier_select,
  // result
  output logic            gate_done,
  output logic            ref_out_of_range
);

  logic [2:0]  ref_sync;
  logic [15:0] gate_cnt;
  logic [10:0] edge_cnt;
  logic        ref_rise;
  logic        in_range;

  // ***************************************************************
  // synchroniser and edge finder
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_sync <= 3'h0;
    end else begin
      ref_sync <= {ref_sync[1:0], ref_clk};
    end
  end

  assign ref_rise = ref_sync[1] & ~ref_sync[2];

  // range of the code; unused codes never pass
  always_comb begin
    if (multiplier_select > MULT_CODE_LAST) begin
      in_range = 1'b0;
    end else begin
      in_range = (edge_cnt >= REF_EDGES_LO[multiplier_select]) &&
                 (edge_cnt <= REF_EDGES_HI[multiplier_select]);
    end
  end

  // ***************************************************************
  // gate counter and edge counter
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_cnt         <= 16'h0000;
      edge_cnt         <= 11'h000;
      gate_done        <= 1'b0;
      ref_out_of_range <= 1'b0;
    end else if (gate_cnt == 16'(GATE_CYCLES - 1)) begin
      gate_cnt         <= 16'h0000;
      edge_cnt         <= 11'h000;
      gate_done        <= 1'b1;
      ref_out_of_range <= ~in_range;
    end else begin
      gate_cnt  <= gate_cnt + 16'h0001;
      gate_done <= 1'b0;
      if (ref_rise && edge_cnt != 11'h7FF) begin
        edge_cnt <= edge_cnt + 11'h001;
      end
    end
  end

endmodule : pmic_ref_meter

// File: hw/pmic_top.sv
/*
 * pmic_top: PLL multiplier select, reference frequency check, PLL lock
 * tracking and the three-level top interrupt registers with the
 * open-drain interrupt pin.
 * Assumes the serial framing logic delivers register accesses on the
 * same clock, and LIN channel logic delivers one-cycle event pulses.
 */
`timescale 1ns/10ps
module pmic_top
  import pmic_pkg::*;
#(
  parameter int GATE_CYCLES = FREQ_GATE_CYCLES,
  parameter int LOCK_GATES  = LOCK_GOOD_GATES
) (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // reference clock pin
  input  wire logic       ref_clk,
  // register port from the serial framing logic
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // event pulses from the rest of the device
  input  wire logic [3:0] wakeup_evt,
  input  wire logic       overtemp_evt,
  input  wire logic       overtemp_level,
  input  wire logic       serial_error_evt,
  input  wire logic       sleep_request_fail_evt,
  // second-level channel events and enables, bit 3 is channel 4
  input  wire logic [3:0] ch_error_evt,
  input  wire logic [3:0] ch_status_evt,
  input  wire logic [3:0] ch_error_lvl2_en,
  input  wire logic [3:0] ch_status_lvl2_en,
  // per-channel flag set pulses toward the channel registers
  output logic [3:0]      channel_error_flags_set,
  output logic [3:0]      channel_status_flags_set,
  // PLL control
  output logic [9:0]      pll_mult_x10,
  output logic            pll_lock_status,
  // open-drain interrupt pin
  output logic            irq_out_n,
  output logic            irq_out_n_oe
);

  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [3:0]  multiplier_select;
  logic [3:0]  wakeup_irq_enable;
  logic [5:1]  system_irq_enable;
  logic [7:0]  channel_irq_enable;
  logic [7:0]  wakeup_init_irq_flags;
  logic [5:0]  system_irq_flags;
  logic [7:0]  channel_irq_summary;
  logic        ref_freq_fail_status;
  logic        fail_prev;
  logic        gate_done;
  logic        ref_bad;
  logic [3:0]  good_cnt;
  logic        lock_rise;
  logic        lock_fall;
  pmic_lock_e  lock_state;
  logic        wr_flags1;
  logic        wr_flags2;
  logic [7:0]  next_wakeup_flags;
  logic [5:0]  next_system_flags;
  logic [5:0]  sys_set;
  logic [3:0]  err_set;
  logic [3:0]  stat_set;
  logic [3:0]  err_clr;
  logic [3:0]  stat_clr;
  logic [7:0]  next_rdata;

  // channel error register address, ch is 0 for channel 1
  function automatic logic [7:0] ch_err_addr(input int ch);
    unique case (ch)
      0:       ch_err_addr = CH1_ERROR_FLAGS_ADDR;
      1:       ch_err_addr = CH2_ERROR_FLAGS_ADDR;
      2:       ch_err_addr = CH3_ERROR_FLAGS_ADDR;
      default: ch_err_addr = CH4_ERROR_FLAGS_ADDR;
    endcase
  endfunction : ch_err_addr

  // ***************************************************************
  // reset release
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync <= 2'b00;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end

  assign rst_n = rst_sync[1];

  // ***************************************************************
  // reference frequency check
  // ***************************************************************
  pmic_ref_meter #(
    .GATE_CYCLES      (GATE_CYCLES)
  ) u_meter (
    .core_clk         (core_clk),
    .rst_n            (rst_n),
    .ref_clk          (ref_clk),
    .multiplier_select(multiplier_select),
    .gate_done        (gate_done),
    .ref_out_of_range (ref_bad)
  );

  // fail status follows each finished gate
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_freq_fail_status <= 1'b0;
      fail_prev            <= 1'b0;
    end else begin
      fail_prev <= ref_freq_fail_status;
      if (gate_done) begin
        ref_freq_fail_status <= ref_bad;
      end
    end
  end

  // ***************************************************************
  // lock tracking: a run of good gates locks, a bad gate or a new
  // code drops lock
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_state <= PMIC_UNLOCKED;
      good_cnt   <= 4'h0;
    end else if (reg_wr && reg_addr == PLL_MULTIPLIER_CONFIG_ADDR) begin
      lock_state <= PMIC_UNLOCKED;
      good_cnt   <= 4'h0;
    end else if (gate_done) begin
      unique case (lock_state)
        PMIC_UNLOCKED, PMIC_SETTLING: begin
          if (ref_bad) begin
            lock_state <= PMIC_UNLOCKED;
            good_cnt   <= 4'h0;
          end else if (good_cnt >= 4'(LOCK_GATES - 1)) begin
            lock_state <= PMIC_LOCKED;
          end else begin
            lock_state <= PMIC_SETTLING;
            good_cnt   <= good_cnt + 4'h1;
          end
        end
        PMIC_LOCKED: begin
          if (ref_bad) begin
            lock_state <= PMIC_UNLOCKED;
            good_cnt   <= 4'h0;
          end
        end
      endcase
    end
  end

  // lock output and its edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_lock_status <= 1'b0;
    end else begin
      pll_lock_status <= (lock_state == PMIC_LOCKED);
    end
  end

  assign lock_rise = (lock_state == PMIC_LOCKED) & ~pll_lock_status;
  assign lock_fall = (lock_state != PMIC_LOCKED) & pll_lock_status;

  // ***************************************************************
  // enable and configuration registers
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      multiplier_select  <= MULT_SEL_RESET;
      wakeup_irq_enable  <= WAKEUP_EN_RESET;
      system_irq_enable  <= SYSTEM_EN_RESET[5:1];
      channel_irq_enable <= CHANNEL_EN_RESET;
    end else if (reg_wr) begin
      unique case (reg_addr)
        PLL_MULTIPLIER_CONFIG_ADDR:
          multiplier_select <= reg_wdata[MULT_SEL_MSB:0];
        WAKEUP_IRQ_ENABLE_ADDR:
          wakeup_irq_enable <= reg_wdata[3:0];
        SYSTEM_IRQ_ENABLE_ADDR:
          system_irq_enable <= reg_wdata[5:1] & SYSTEM_EN_MASK;
        CHANNEL_IRQ_ENABLE_ADDR:
          channel_irq_enable <= reg_wdata;
        default: ;
      endcase
    end
  end

  // factor presented to the clock generator, x10 fixed point
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_mult_x10 <= MULT_X10[MULT_SEL_RESET];
    end else if (multiplier_select <= MULT_CODE_LAST) begin
      pll_mult_x10 <= MULT_X10[multiplier_select];
    end
  end

  // ***************************************************************
  // first and second status registers, set wins over clear
  // ***************************************************************
  assign wr_flags1 = reg_wr && reg_addr == WAKEUP_INIT_IRQ_FLAGS_ADDR;
  assign wr_flags2 = reg_wr && reg_addr == SYSTEM_IRQ_FLAGS_ADDR;

  always_comb begin
    sys_set = 6'h00;
    sys_set[OVERTEMP_BIT]   = overtemp_evt & system_irq_enable[OVERTEMP_BIT];
    sys_set[PLL_UNLOCK_BIT] = lock_fall
                              & system_irq_enable[PLL_UNLOCK_BIT];
    sys_set[PLL_LOCK_BIT]   = lock_rise & system_irq_enable[PLL_LOCK_BIT];
    sys_set[REF_FAIL_BIT]   = ref_freq_fail_status & ~fail_prev
                              & system_irq_enable[REF_FAIL_BIT];
    sys_set[SERIAL_ERR_BIT] = serial_error_evt
                              & system_irq_enable[SERIAL_ERR_BIT];
    sys_set[SLEEP_FAIL_BIT] = sleep_request_fail_evt;
    next_wakeup_flags = wakeup_init_irq_flags;
    next_system_flags = system_irq_flags;
    if (wr_flags1) begin
      next_wakeup_flags = wakeup_init_irq_flags & ~reg_wdata;
    end
    if (wr_flags2) begin
      next_system_flags = system_irq_flags & ~reg_wdata[5:0];
    end
    next_wakeup_flags[3:0] = next_wakeup_flags[3:0]
                             | (wakeup_evt & wakeup_irq_enable);
    next_system_flags = next_system_flags | sys_set;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_init_irq_flags <= WAKEUP_FLAGS_RESET;
      system_irq_flags      <= SYSTEM_FLAGS_RESET[5:0];
    end else begin
      wakeup_init_irq_flags <= next_wakeup_flags & 8'h8F;
      system_irq_flags      <= next_system_flags;
    end
  end

  // ***************************************************************
  // channel summary: set needs both enable levels, host clears it
  // through the channel flag registers
  // ***************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      assign err_set[ch]  = ch_error_evt[ch] & ch_error_lvl2_en[ch]
                            & channel_irq_enable[CH_ERROR_LSB + ch];
      assign stat_set[ch] = ch_status_evt[ch] & ch_status_lvl2_en[ch]
                            & channel_irq_enable[ch];
      assign err_clr[ch]  = reg_wr && (reg_wdata != 8'h00)
                            && reg_addr == ch_err_addr(ch);
      assign stat_clr[ch] = reg_wr && (reg_wdata != 8'h00)
                            && reg_addr == ch_err_addr(ch)
                               + CH_STATUS_FLAGS_STEP;
    end
  endgenerate

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      channel_irq_summary      <= 8'h00;
      channel_error_flags_set  <= 4'h0;
      channel_status_flags_set <= 4'h0;
    end else begin
      channel_irq_summary[7:4] <= (channel_irq_summary[7:4] & ~err_clr)
                                  | err_set;
      channel_irq_summary[3:0] <= (channel_irq_summary[3:0] & ~stat_clr)
                                  | stat_set;
      channel_error_flags_set  <= err_set;
      channel_status_flags_set <= stat_set;
    end
  end

  // ***************************************************************
  // interrupt pin: only ever driven low
  // ***************************************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out_n    <= 1'b0;
      irq_out_n_oe <= 1'b0;
    end else begin
      irq_out_n    <= 1'b0;
      irq_out_n_oe <= wakeup_init_irq_flags[INIT_DONE_BIT]
        | |(wakeup_init_irq_flags[3:0] & wakeup_irq_enable)
        | system_irq_flags[SLEEP_FAIL_BIT]
        | |(system_irq_flags[5:1] & system_irq_enable)
        | |(channel_irq_summary & channel_irq_enable);
    end
  end

  // ***************************************************************
  // register read, data one cycle after the read strobe
  // ***************************************************************
  always_comb begin
    next_rdata = 8'h00;
    unique case (reg_addr)
      PLL_MULTIPLIER_CONFIG_ADDR: next_rdata = {4'h0, multiplier_select};
      WAKEUP_IRQ_ENABLE_ADDR:     next_rdata = {4'h0, wakeup_irq_enable};
      SYSTEM_IRQ_ENABLE_ADDR:     next_rdata = {2'h0, system_irq_enable, 1'b0};
      CHANNEL_IRQ_ENABLE_ADDR:    next_rdata = channel_irq_enable;
      WAKEUP_INIT_IRQ_FLAGS_ADDR: next_rdata = wakeup_init_irq_flags;
      SYSTEM_IRQ_FLAGS_ADDR:      next_rdata = {2'h0, system_irq_flags};
      CHANNEL_IRQ_SUMMARY_ADDR:   next_rdata = channel_irq_summary;
      DEVICE_STATUS_ADDR: begin
        next_rdata[OVERTEMP_BIT] = overtemp_level;
        next_rdata[PLL_LOCK_BIT] = pll_lock_status;
        next_rdata[REF_FAIL_BIT] = ref_freq_fail_status;
      end
      default:                    next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule : pmic_top

// File: tb/pmic_ref_src.sv
/* pmic_ref_src: reference clock source and the pulled-up interrupt wire.
   Assumes the reference runs free and the pin has a pull-up. */
`timescale 1ns/10ps
module pmic_ref_src (
  // reference clock and interrupt pin
  output logic      ref_clk,
  input wire logic  irq_out_n,
  input wire logic  irq_out_n_oe,
  output wire logic irq_pin
);
  // free-running 8 MHz reference, phase unrelated to the core clock
  initial begin
    ref_clk = 1'b0;
    #3.7;
    forever #62.5 ref_clk = ~ref_clk;
  end
  // wire level: pulled up unless the device sinks it
  assign irq_pin = irq_out_n_oe ? irq_out_n : 1'b1;
endmodule : pmic_ref_src

// File: tb/pmic_top_props.sv
/* pmic_chk: port-level checks on pmic_top.
   Assumes one core clock domain and rstn active low. */
`timescale 1ns/10ps
module pmic_chk (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rstn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // events and outputs
  input wire logic       sleep_request_fail_evt,
  input wire logic [3:0] ch_error_evt,
  input wire logic [3:0] ch_error_lvl2_en,
  input wire logic [3:0] channel_error_flags_set,
  input wire logic [9:0] pll_mult_x10,
  input wire logic       irq_out_n,
  input wire logic       irq_out_n_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // ****************************************
  // properties
  // ****************************************
  property p_drive_low; irq_out_n == 1'b0;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("pin high");
  property p_mult_a; reg_wr && reg_addr == 8'h01 && reg_wdata[3:0] == 4'hA
    |-> ##[1:3] pll_mult_x10 == 10'd39; endproperty
  a_mult_a: assert property (p_mult_a) else $error("factor wrong");
  property p_en1_rsv; reg_rd && reg_addr == 8'h02 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_en1_rsv: assert property (p_en1_rsv) else $error("en1 bits");
  property p_en2_rsv; reg_rd && reg_addr == 8'h03 |=> (reg_rdata & 8'hC1) == 0;
  endproperty
  a_en2_rsv: assert property (p_en2_rsv) else $error("en2 bits");
  property p_fl1_rsv; reg_rd && reg_addr == 8'h10 |=> reg_rdata[6:4] == 3'h0;
  endproperty
  a_fl1_rsv: assert property (p_fl1_rsv) else $error("fl1 bits");
  property p_fl2_rsv; reg_rd && reg_addr == 8'h11 |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_fl2_rsv: assert property (p_fl2_rsv) else $error("fl2 bits");
  property p_sleep_pin; sleep_request_fail_evt |-> ##2 irq_out_n_oe;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin) else $error("no pin");
  property p_ch_gate; (channel_error_flags_set
    & ~$past(ch_error_evt & ch_error_lvl2_en)) == 4'h0; endproperty
  a_ch_gate: assert property (p_ch_gate) else $error("flag set");
  c_sum_wr: cover property (reg_wr && reg_addr == 8'h12);
  c_pin_rel: cover property ($fell(irq_out_n_oe));
  c_ch_set: cover property (channel_error_flags_set != 4'h0);
endmodule : pmic_chk
bind pmic_top pmic_chk u_chk (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sleep_request_fail_evt(sleep_request_fail_evt),
  .ch_error_evt(ch_error_evt), .ch_error_lvl2_en(ch_error_lvl2_en),
  .channel_error_flags_set(channel_error_flags_set),
  .pll_mult_x10(pll_mult_x10), .irq_out_n(irq_out_n),
  .irq_out_n_oe(irq_out_n_oe));

// File: tb/testbench.sv
/* testbench: drives pmic_top registers, events and reference clock.
   Assumes pmic_ref_src as far side and pmic_chk bound to the top. */
`timescale 1ns/10ps
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module testbench;
  logic       core_clk, rstn, ref_clk, reg_wr, reg_rd, irq_out_n;
  logic       irq_out_n_oe, irq_pin, pll_lock_status, ot_evt, se_evt, sf_evt;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, ex, ec;
  logic [3:0] wk_evt, ce_evt, cs_evt, ce_en, cs_en, ce_set, cs_set;
  logic [9:0] pll_mult_x10;
  int         fails, checked;
  logic [7:0] ra [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12,
    8'h05};
  logic [7:0] rr [8] = '{8'h0A, 8'h0F, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00,
    8'h00};
  logic [9:0] mt [11] = '{10'd780, 10'd650, 10'd390, 10'd280, 10'd200,
    10'd150, 10'd110, 10'd85, 10'd64, 10'd48, 10'd39};
  // shortened gate: 8 MHz gives 80 edges, good for code 2, bad for code A
  pmic_top #(.GATE_CYCLES(1000), .LOCK_GATES(2)) dut (.core_clk(core_clk),
    .rstn(rstn), .ref_clk(ref_clk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wakeup_evt(wk_evt), .overtemp_evt(ot_evt),
    .overtemp_level(1'b0), .serial_error_evt(se_evt),
    .sleep_request_fail_evt(sf_evt), .ch_error_evt(ce_evt),
    .ch_status_evt(cs_evt), .ch_error_lvl2_en(ce_en),
    .ch_status_lvl2_en(cs_en), .channel_error_flags_set(ce_set),
    .channel_status_flags_set(cs_set), .pll_mult_x10(pll_mult_x10),
    .pll_lock_status(pll_lock_status), .irq_out_n(irq_out_n),
    .irq_out_n_oe(irq_out_n_oe));
  pmic_ref_src u_ref (.ref_clk(ref_clk), .irq_out_n(irq_out_n),
    .irq_out_n_oe(irq_out_n_oe), .irq_pin(irq_pin));
  // core clock 100 MHz
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // channel flag address: error ones first, then status ones
  function automatic logic [7:0] ea(input int i);
    return 8'h50 + 8'(i % 4) * 8'h30 + 8'(i / 4);
  endfunction : ea
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask : rc
  // one-cycle pulses on the event inputs
  task automatic ev(input logic [3:0] w, input logic [2:0] s,
    input logic [7:0] c);
    @(posedge core_clk);
    wk_evt <= w;
    {ot_evt, se_evt, sf_evt} <= s;
    {ce_evt, cs_evt} <= c;
    @(posedge core_clk);
    {wk_evt, ot_evt, se_evt, sf_evt, ce_evt, cs_evt} <= '0;
    #1;
  endtask : ev
  task automatic give_verdict;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    give_verdict();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'hD909B28C));
    {reg_wr, reg_rd, ot_evt, se_evt, sf_evt, reg_addr, reg_wdata} = '0;
    {wk_evt, ce_evt, cs_evt, ce_en, cs_en} = '0;
    {rstn, fails, checked} = '0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (ra[i]) rc(ra[i], rr[i], "reset");
    `CHK("mult", 10'd39, pll_mult_x10)
    `CHK("pin", 1'b0, irq_pin)
    repeat (1200) @(posedge core_clk);
    rc(8'h13, 8'h04, "ref fail");
    rc(8'h11, 8'h00, "fail masked");
    $display("test reset done");
    wr(8'h10, 8'h00);
    rc(8'h10, 8'h80, "w0");
    wr(8'h10, 8'h80);
    rc(8'h10, 8'h00, "w1");
    `CHK("pin", 1'b1, irq_pin)
    rv = 8'h01 << $urandom_range(3, 0);
    ev(rv[3:0], 3'b000, 8'h00);
    rc(8'h10, rv, "wake");
    `CHK("pin", 1'b0, irq_pin)
    wr(8'h10, rv);
    wr(8'h02, 8'hF0);
    ev(rv[3:0], 3'b000, 8'h00);
    rc(8'h10, 8'h00, "wake off");
    wr(8'h02, 8'hFF);
    rc(8'h02, 8'h0F, "en1");
    $display("test wake done");
    repeat (4) begin
      rv = 8'($urandom) & 8'hE7;
      wr(8'h03, rv);
      rc(8'h03, rv & 8'h3E, "en2");
      ev(4'h0, 3'b111, 8'h00);
      rc(8'h11, (rv & 8'h22) | 8'h01, "sys");
      wr(8'h11, 8'hFF);
      rc(8'h11, 8'h00, "sys clr");
      `CHK("pin", 1'b1, irq_pin)
    end
    wr(8'h03, 8'h00);
    $display("test system done");
    repeat (3) begin
      // bits 7 and 0 always see both enables and an event
      rv = 8'($urandom) | 8'h81;
      wr(8'h04, rv);
      rc(8'h04, rv, "en3");
      ex = 8'($urandom) | 8'h81;
      @(posedge core_clk);
      {ce_en, cs_en} <= ex;
      ec = 8'($urandom) | 8'h81;
      ex = ex & rv & ec;
      ev(4'h0, 3'b000, ec);
      `CHK("set", ex, {ce_set, cs_set})
      rc(8'h12, ex, "sum");
      wr(8'h12, 8'hFF);
      rc(8'h12, ex, "sum ro");
      `CHK("pin", ex == 8'h00, irq_pin)
      for (int i = 0; i < 8; i++) begin
        wr(ea(i), 8'h01);
        ex[(i + 4) % 8] = 1'b0;
        rc(8'h12, ex, "sum clr");
      end
    end
    $display("test channel done");
    for (int c = 0; c < 11; c++) begin
      wr(8'h01, 8'(c));
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("mult", mt[c], pll_mult_x10)
    end
    wr(8'h03, 8'h08);
    wr(8'h01, 8'hF2);
    rc(8'h01, 8'h02, "cfg");
    wr(8'h11, 8'hFF);
    repeat (3200) @(posedge core_clk);
    `CHK("lock", 1'b1, pll_lock_status)
    rc(8'h13, 8'h08, "locked");
    rc(8'h11, 8'h08, "lock irq");
    wr(8'h03, 8'h14);
    wr(8'h01, 8'h0A);
    repeat (2200) @(posedge core_clk);
    `CHK("lock", 1'b0, pll_lock_status)
    rc(8'h13, 8'h04, "unlocked");
    rc(8'h11, 8'h1C, "fail irq");
    `CHK("pin", 1'b0, irq_pin)
    wr(8'h01, 8'h0B);
    rc(8'h01, 8'h0B, "unused");
    `CHK("mult", 10'd39, pll_mult_x10)
    $display("test pll done");
    give_verdict();
  end
endmodule : testbench
